/* File: design/ppfs_pkg.sv */
// Package: constants for the port pin function select block
//----------------------------------------------------------------------
// Notes on behaviour
//----------------------------------------------------------------------
// Notes on behaviour
// - Threshold bits 1:0 pick port 8 level: 00 half, 01 0.35, 10 0.70; 11 forbidden.
// - Threshold bits 3:2 pick port 9 level with the same encoding.
// - Threshold bits 7:4 are unimplemented and read as zero.
// - Timer B pin drives pulse output in waveform mode when not disabled.
// - Timer B pin drives one-shot output in one-shot mode when not disabled.
// - Timer B pin drives wait one-shot output in that mode when not disabled.
// - Pull-up acts only while the pin is an input.
// - Port 8 high drive bit acts only while the pin is an output.
// - Chip-select mode 1x gives output, 01 with direction 0 gives input.
// - Chip-select open-drain bit makes the chip-select output pull low only.
// - Serial data-in pin drives serial data when serial mode needs output.
// - Shared data pin carries serial data when switch 0 and timer J0 unused.
// - Serial data outputs open-drain only when open-drain 1 and bidirectional 0.
// - Port 8 pin 4 drives channel B when routed there and enabled.
// - Channel pin drives PWM waveform in single PWM mode when enabled.
// - Io control 001/01x gives compare output; 1xx with direction 0 gives capture.
// - Channel B route: 00 none, 01 pin 6, 10 pin 5, 11 pin 4.
// - Channel D route bit takes port 8 pin 4 over channel B.
package ppfs_pkg;
    //------------------------------------------------------------------
    // Register map
    //------------------------------------------------------------------
    localparam logic [9:0] PPFS_THRESH_ADDR  = 10'h1F7;
    localparam logic [7:0] PPFS_THRESH_RESET = 8'h00;
    localparam logic [7:0] PPFS_THRESH_MASK  = 8'h0F;
    localparam int         PPFS_P8_LSB       = 0;
    localparam int         PPFS_P9_LSB       = 2;
    //------------------------------------------------------------------
    // Encodings
    //------------------------------------------------------------------
    localparam logic [1:0] PPFS_TH_HALF = 2'h0;
    localparam logic [1:0] PPFS_TH_LOW  = 2'h1;
    localparam logic [1:0] PPFS_TH_HIGH = 2'h2;
    localparam logic [1:0] PPFS_TB_PULSE   = 2'h1;
    localparam logic [1:0] PPFS_TB_ONESHOT = 2'h2;
    localparam logic [1:0] PPFS_TB_WAIT    = 2'h3;
    localparam logic [1:0] PPFS_CB_NONE = 2'h0;
    localparam logic [1:0] PPFS_CB_P86  = 2'h1;
    localparam logic [1:0] PPFS_CB_P85  = 2'h2;
    localparam logic [1:0] PPFS_CB_P84  = 2'h3;
endpackage

/* File: design/ppfs_top.sv */
// Module: port pin function select for ports 2 and 8 with threshold register
`timescale 1ns/10ps
`default_nettype none
module ppfs_top
    import ppfs_pkg::*;
(
    // Clock and reset
    input  wire logic       clock_i,
    input  wire logic       reset_n_i,
    // Register access
    input  wire logic [9:0] reg_addr_i,
    input  wire logic       reg_wr_i,
    input  wire logic [7:0] reg_wdata_i,
    output logic      [7:0] reg_rdata_o,
    // Port direction and pin controls
    input  wire logic [7:0] port2_direction_i,
    input  wire logic [7:0] port8_direction_i,
    input  wire logic [7:0] port2_pullup_i,
    input  wire logic [7:0] port8_pullup_i,
    input  wire logic [7:0] port8_high_drive_i,
    input  wire logic [7:0] port2_data_i,
    input  wire logic [7:0] port8_data_i,
    // Timer B (index 0 on pin 1, index 1 on pin 0)
    input  wire logic [1:0] timer_b_output_disable_i,
    input  wire logic [3:0] timer_mode_field_i,
    input  wire logic [1:0] timer_b_wave_i,
    // Interrupt enables: p2_2, p2_3, p8_0, p8_1, keys p2_4..p2_7
    input  wire logic [7:0] irq_enable_i,
    // Serial unit
    input  wire logic [1:0] chip_select_mode_field_i,
    input  wire logic       chip_select_open_drain_i,
    input  wire logic       serial_open_drain_i,
    input  wire logic       bidirectional_mode_i,
    input  wire logic       serial_clock_select_i,
    input  wire logic       serial_clk_out_en_i,
    input  wire logic       serial_data_out_en_i,
    input  wire logic       serial_cs_i,
    input  wire logic       serial_clk_i,
    input  wire logic       serial_data_i,
    input  wire logic       serial_twowire_switch_i,
    input  wire logic       twowire_interface_enable_i,
    input  wire logic       twowire_scl_low_i,
    input  wire logic       twowire_sda_low_i,
    // Timer J0
    input  wire logic [1:0] timer_j0_pin_route_i,
    input  wire logic       timer_j0_output_disable_i,
    input  wire logic       timer_j0_out_i,
    // Timer RC channels B and D
    input  wire logic [1:0] channel_b_route_field_i,
    input  wire logic       channel_d_route_bit_i,
    input  wire logic       channel_b_output_disable_i,
    input  wire logic       channel_d_output_disable_i,
    input  wire logic       dual_pwm_mode_bit_i,
    input  wire logic       pwm_b_i,
    input  wire logic       pwm_d_i,
    input  wire logic [2:0] channel_b_io_control_i,
    input  wire logic [2:0] channel_d_io_control_i,
    input  wire logic       channel_b_wave_i,
    input  wire logic       channel_d_wave_i,
    // Pins
    input  wire logic [7:0] port2_pin_i,
    input  wire logic [7:0] port8_pin_i,
    output logic      [7:0] port2_pin_o,
    output logic      [7:0] port2_pin_oe_o,
    output logic      [7:0] port8_pin_o,
    output logic      [7:0] port8_pin_oe_o,
    output logic      [7:0] port2_pullup_o,
    output logic      [7:0] port8_pullup_o,
    output logic      [7:0] port8_high_drive_o,
    output logic      [1:0] port8_threshold_o,
    output logic      [1:0] port9_threshold_o,
    // Peripheral inputs, synchronised
    output logic      [7:0] irq_in_o,
    output logic            serial_cs_in_o,
    output logic            serial_clk_in_o,
    output logic            serial_data_in_o,
    output logic            channel_b_capture_o,
    output logic            channel_d_capture_o,
    output logic            twowire_scl_in_o,
    output logic            twowire_sda_in_o
);
    //------------------------------------------------------------------
    // Threshold register
    //------------------------------------------------------------------
    logic [7:0] thresh_r;
    logic [7:0] p2_s1_r, p2_s2_r, p8_s1_r, p8_s2_r;
    logic [7:0] p2_out_nxt, p2_oe_nxt, p8_out_nxt, p8_oe_nxt;
    logic [7:0] p2_isin_nxt, p8_isin_nxt;

    // Unimplemented upper bits are never stored, so they read zero
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            thresh_r <= PPFS_THRESH_RESET;
        end else if (reg_wr_i && reg_addr_i == PPFS_THRESH_ADDR) begin
            thresh_r <= reg_wdata_i & PPFS_THRESH_MASK;
        end
    end

    // Read data; other addresses answer zero
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            reg_rdata_o <= 8'h00;
        end else begin
            reg_rdata_o <= (reg_addr_i == PPFS_THRESH_ADDR) ? thresh_r : 8'h00;
        end
    end

    // Threshold selections; code 11 is forbidden and passed as written
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            port8_threshold_o <= PPFS_TH_HALF;
            port9_threshold_o <= PPFS_TH_HALF;
        end else begin
            port8_threshold_o <= thresh_r[PPFS_P8_LSB +: 2];
            port9_threshold_o <= thresh_r[PPFS_P9_LSB +: 2];
        end
    end

    //------------------------------------------------------------------
    // Pin input synchronisers
    //------------------------------------------------------------------
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            p2_s1_r <= 8'h00;
            p2_s2_r <= 8'h00;
            p8_s1_r <= 8'h00;
            p8_s2_r <= 8'h00;
        end else begin
            p2_s1_r <= port2_pin_i;
            p2_s2_r <= p2_s1_r;
            p8_s1_r <= port8_pin_i;
            p8_s2_r <= p8_s1_r;
        end
    end

    //------------------------------------------------------------------
    // Function selection
    //------------------------------------------------------------------
    function automatic logic tb_active(input logic dis, input logic [1:0] mode);
        tb_active = !dis && (mode == PPFS_TB_PULSE || mode == PPFS_TB_ONESHOT || mode == PPFS_TB_WAIT);
    endfunction

    // Compare output for io codes 001 and 01x
    function automatic logic rc_compare(input logic [2:0] io);
        rc_compare = !io[2] && (io[1] || io[0]);
    endfunction

    logic twi_on, ch_d_on, ch_b_p84, ch_b_p85, ch_b_p86, ch_b_drv, sd_in_out, sd_data_out;
    always_comb begin
        twi_on   = serial_twowire_switch_i && twowire_interface_enable_i;
        ch_d_on  = channel_d_route_bit_i;
        ch_b_p84 = !ch_d_on && channel_b_route_field_i == PPFS_CB_P84;
        ch_b_p86 = channel_b_route_field_i == PPFS_CB_P86;
        ch_b_p85 = channel_b_route_field_i == PPFS_CB_P85;
        ch_b_drv = !channel_b_output_disable_i
                   && (!dual_pwm_mode_bit_i || pwm_b_i || rc_compare(channel_b_io_control_i));
        sd_in_out   = !serial_twowire_switch_i && serial_data_out_en_i && bidirectional_mode_i;
        sd_data_out = !serial_twowire_switch_i && timer_j0_output_disable_i
                      && timer_j0_pin_route_i != 2'h1 && serial_data_out_en_i && !bidirectional_mode_i;
    end

    // Port 2 pins: timer B outputs on pins 0 and 1, rest general
    always_comb begin
        p2_out_nxt = port2_data_i;
        p2_oe_nxt  = port2_direction_i;
        if (tb_active(timer_b_output_disable_i[1], timer_mode_field_i[3:2])) begin
            p2_out_nxt[0] = timer_b_wave_i[1];
            p2_oe_nxt[0]  = 1'b1;
        end
        if (tb_active(timer_b_output_disable_i[0], timer_mode_field_i[1:0])) begin
            p2_out_nxt[1] = timer_b_wave_i[0];
            p2_oe_nxt[1]  = 1'b1;
        end
        p2_isin_nxt = ~p2_oe_nxt;
    end

    // Port 8 pins 0..6 with serial, two-wire, timer J0 and RC
    always_comb begin
        p8_out_nxt = port8_data_i;
        p8_oe_nxt  = port8_direction_i;
        // Chip select pin
        if (chip_select_mode_field_i[1]) begin
            p8_out_nxt[0] = chip_select_open_drain_i ? 1'b0 : serial_cs_i;
            p8_oe_nxt[0]  = chip_select_open_drain_i ? !serial_cs_i : 1'b1;
        end else if (chip_select_mode_field_i == 2'h1) begin
            p8_oe_nxt[0] = 1'b0;
        end
        // Data-in pin used as output in bidirectional serial mode
        if (sd_in_out) begin
            p8_out_nxt[1] = serial_data_i;
            p8_oe_nxt[1]  = 1'b1;
        end
        // Clock pin; open-drain drives only low, output enable follows the inverted clock
        if (twi_on) begin
            p8_out_nxt[2] = 1'b0;
            p8_oe_nxt[2]  = twowire_scl_low_i;
        end else if (!serial_twowire_switch_i && serial_clock_select_i) begin
            p8_out_nxt[2] = serial_open_drain_i ? 1'b0 : serial_clk_i;
            p8_oe_nxt[2]  = serial_clk_out_en_i && (serial_open_drain_i ? !serial_clk_i : 1'b1);
        end
        // Shared data pin
        if (twi_on) begin
            p8_out_nxt[3] = 1'b0;
            p8_oe_nxt[3]  = twowire_sda_low_i;
        end else if (!timer_j0_output_disable_i && timer_j0_pin_route_i == 2'h1) begin
            p8_out_nxt[3] = timer_j0_out_i;
            p8_oe_nxt[3]  = 1'b1;
        end else if (sd_data_out) begin
            p8_out_nxt[3] = serial_open_drain_i ? 1'b0 : serial_data_i;
            p8_oe_nxt[3]  = serial_open_drain_i ? !serial_data_i : 1'b1;
        end
        // Pin 4: channel D wins over channel B
        if (ch_d_on && !channel_d_output_disable_i && dual_pwm_mode_bit_i
            && (pwm_d_i || rc_compare(channel_d_io_control_i))) begin
            p8_out_nxt[4] = channel_d_wave_i;
            p8_oe_nxt[4]  = 1'b1;
        end else if (ch_d_on && channel_d_io_control_i[2]) begin
            p8_oe_nxt[4] = 1'b0;
        end else if (ch_b_p84 && ch_b_drv) begin
            p8_out_nxt[4] = channel_b_wave_i;
            p8_oe_nxt[4]  = 1'b1;
        end
        // Pins 5 and 6 carry channel B when routed there
        if (ch_b_p85 && ch_b_drv) begin
            p8_out_nxt[5] = channel_b_wave_i;
            p8_oe_nxt[5]  = 1'b1;
        end
        if (ch_b_p86 && ch_b_drv) begin
            p8_out_nxt[6] = channel_b_wave_i;
            p8_oe_nxt[6]  = 1'b1;
        end
        p8_isin_nxt = ~p8_oe_nxt;
    end

    //------------------------------------------------------------------
    // Registered pin outputs
    //------------------------------------------------------------------
    // Registering costs one cycle of latency but keeps pins glitch free
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            port2_pin_o        <= 8'h00;
            port2_pin_oe_o     <= 8'h00;
            port8_pin_o        <= 8'h00;
            port8_pin_oe_o     <= 8'h00;
            port2_pullup_o     <= 8'h00;
            port8_pullup_o     <= 8'h00;
            port8_high_drive_o <= 8'h00;
        end else begin
            port2_pin_o        <= p2_out_nxt;
            port2_pin_oe_o     <= p2_oe_nxt;
            port8_pin_o        <= p8_out_nxt;
            port8_pin_oe_o     <= p8_oe_nxt;
            port2_pullup_o     <= port2_pullup_i & p2_isin_nxt;
            port8_pullup_o     <= port8_pullup_i & p8_isin_nxt;
            port8_high_drive_o <= port8_high_drive_i & ~p8_isin_nxt;
        end
    end

    // Peripheral inputs gated by enable and input direction; serial clock is ungated, two-wire by enable only
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            irq_in_o            <= 8'h00;
            serial_cs_in_o      <= 1'b0;
            serial_clk_in_o     <= 1'b0;
            serial_data_in_o    <= 1'b0;
            channel_b_capture_o <= 1'b0;
            channel_d_capture_o <= 1'b0;
            twowire_scl_in_o    <= 1'b1;
            twowire_sda_in_o    <= 1'b1;
        end else begin
            irq_in_o <= irq_enable_i & ~{port2_direction_i[7:4], port8_direction_i[1:0],
                        port2_direction_i[3:2]} & {p2_s2_r[7:4], p8_s2_r[1:0], p2_s2_r[3:2]};
            serial_cs_in_o      <= chip_select_mode_field_i == 2'h1 && !port8_direction_i[0] && p8_s2_r[0];
            serial_clk_in_o     <= p8_s2_r[2];
            serial_data_in_o    <= !serial_twowire_switch_i && !port8_direction_i[1] && p8_s2_r[1];
            channel_b_capture_o <= channel_b_io_control_i[2] && dual_pwm_mode_bit_i && !pwm_b_i
                && (p8_s2_r & ~port8_direction_i & {1'b0, ch_b_p86, ch_b_p85, ch_b_p84, 4'h0}) != 8'h00;
            channel_d_capture_o <= channel_d_io_control_i[2] && ch_d_on && !port8_direction_i[4] && p8_s2_r[4];
            twowire_scl_in_o    <= !twi_on || p8_s2_r[2];
            twowire_sda_in_o    <= !twi_on || p8_s2_r[3];
        end
    end

    //------------------------------------------------------------------
    // Assertions
    //------------------------------------------------------------------
    a_upper_bits_zero: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        reg_rdata_o[7:4] == 4'h0) else $error("threshold upper bits nonzero");
    a_p8_thresh_map: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        port8_threshold_o == $past(thresh_r[1:0])) else $error("port 8 threshold wrong");
    a_p9_thresh_map: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        port9_threshold_o == $past(thresh_r[3:2])) else $error("port 9 threshold wrong");
    a_timer_b_drive: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        (!timer_b_output_disable_i[0] && timer_mode_field_i[1:0] != 2'h0) |=> port2_pin_oe_o[1])
        else $error("timer B pin not driven");
    a_pullup_input_only: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        (port8_pullup_o & port8_pin_oe_o) == 8'h00) else $error("pull-up on output pin");
    a_drive_output_only: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        (port8_high_drive_o & ~port8_pin_oe_o) == 8'h00) else $error("high drive on input");
    a_cs_open_drain: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        (chip_select_mode_field_i[1] && chip_select_open_drain_i) |=> !port8_pin_o[0])
        else $error("chip select drives high");
    a_twowire_low_only: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        twi_on |=> !port8_pin_o[2] && !port8_pin_o[3]) else $error("two-wire pin drives high");
    a_irq_gated: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        !irq_enable_i[0] |=> !irq_in_o[0]) else $error("disabled interrupt seen");
    c_twowire_mode: cover property (@(posedge clock_i) disable iff (!reset_n_i) twi_on);
    c_channel_d_out: cover property (@(posedge clock_i) disable iff (!reset_n_i) ch_d_on && p8_oe_nxt[4]);
    c_thresh_write: cover property (@(posedge clock_i) disable iff (!reset_n_i)
        reg_wr_i && reg_addr_i == PPFS_THRESH_ADDR);
endmodule
`default_nettype wire

/* File: bench/ppfs_board_model.sv */
// Board model: pin levels seen by ports 2 and 8
`timescale 1ns/10ps
`default_nettype none
module ppfs_board_model (
    // Clock and reset
    input  wire logic        clock_i,
    input  wire logic        reset_n_i,
    // Design pin side, port 8 above port 2
    input  wire logic [15:0] pin_o_i,
    input  wire logic [15:0] pin_oe_i,
    input  wire logic [15:0] pullup_i,
    // Board drivers
    input  wire logic [15:0] ext_en_i,
    input  wire logic [15:0] ext_val_i,
    // Levels back to the design
    output logic      [15:0] pin_level_o
);
    logic [15:0] last_r;
    // A floating line toggles, so a stale level never passes for a driven one
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            last_r <= 16'h0000;
        end else begin
            last_r <= pin_level_o;
        end
    end
    // Design drive wins, then the board, then the pull-up resistor
    assign pin_level_o = pin_oe_i & pin_o_i | ~pin_oe_i & (ext_en_i & ext_val_i | ~ext_en_i & (pullup_i | ~last_r));
endmodule
`default_nettype wire

/* File: bench/ppfs_top_test.sv */
// Self-checking bench for the port pin function select block
`timescale 1ns/10ps
`default_nettype none
module ppfs_top_test;
    import ppfs_pkg::*;
    //------------------------------------------------------------------
    // Signals
    //------------------------------------------------------------------
    logic clock_i, reset_n_i, reg_wr_i, chip_select_open_drain_i, serial_open_drain_i, bidirectional_mode_i;
    logic serial_clock_select_i, serial_clk_out_en_i, serial_data_out_en_i, serial_cs_i, serial_clk_i, serial_data_i;
    logic serial_twowire_switch_i, twowire_interface_enable_i, twowire_scl_low_i, twowire_sda_low_i, pwm_b_i;
    logic timer_j0_output_disable_i, timer_j0_out_i, channel_d_route_bit_i, channel_b_output_disable_i, pwm_d_i;
    logic channel_d_output_disable_i, dual_pwm_mode_bit_i, channel_b_wave_i, channel_d_wave_i;
    logic [9:0] reg_addr_i;
    logic [7:0] reg_wdata_i, port2_direction_i, port8_direction_i, port2_pullup_i, port8_pullup_i, d;
    logic [7:0] port8_high_drive_i, port2_data_i, port8_data_i, irq_enable_i, port2_pin_i, port8_pin_i;
    logic [3:0] timer_mode_field_i;
    logic [1:0] timer_b_output_disable_i, timer_b_wave_i, chip_select_mode_field_i, timer_j0_pin_route_i;
    logic [1:0] channel_b_route_field_i, port8_threshold_o, port9_threshold_o;
    logic [2:0] channel_b_io_control_i, channel_d_io_control_i;
    logic [7:0] reg_rdata_o, port2_pin_o, port2_pin_oe_o, port8_pin_o, port8_pin_oe_o, port2_pullup_o;
    logic [7:0] port8_pullup_o, port8_high_drive_o, irq_in_o;
    logic serial_cs_in_o, serial_clk_in_o, serial_data_in_o, channel_b_capture_o, channel_d_capture_o;
    logic twowire_scl_in_o, twowire_sda_in_o;
    logic [15:0] ext_en, ext_val, pin_lvl;
    int err_count, compares, seed;
    typedef struct {int id; logic [7:0] mask; logic [7:0] val;} ppfs_note_t;
    ppfs_note_t notes[$], n;
    //------------------------------------------------------------------
    // Design, board and clock
    //------------------------------------------------------------------
    ppfs_top u_ppfs_top (.*);
    ppfs_board_model u_ppfs_board_model (.clock_i(clock_i), .reset_n_i(reset_n_i), .ext_en_i(ext_en),
        .pin_o_i({port8_pin_o, port2_pin_o}), .pin_oe_i({port8_pin_oe_o, port2_pin_oe_o}),
        .pullup_i({port8_pullup_o, port2_pullup_o}), .ext_val_i(ext_val), .pin_level_o(pin_lvl));
    assign {port8_pin_i, port2_pin_i} = pin_lvl;
    always #2.5 clock_i = ~clock_i;
    //------------------------------------------------------------------
    // Tasks
    //------------------------------------------------------------------
    // Wait whole cycles, then step just past the edge so inputs never race it
    task automatic tick(int k);
        repeat (k) @(posedge clock_i);
        #1;
    endtask
    task automatic chk(int id, logic [7:0] mask, logic [7:0] val);
        notes.push_back('{id, mask, val});
    endtask
    // Every function off; timer J0 output disabled so it leaves the shared pin alone
    task automatic idle();
        {reg_wr_i, chip_select_open_drain_i, serial_open_drain_i, bidirectional_mode_i, serial_clock_select_i} = '0;
        {serial_clk_out_en_i, serial_data_out_en_i, serial_twowire_switch_i, twowire_interface_enable_i} = '0;
        {twowire_scl_low_i, twowire_sda_low_i, channel_d_route_bit_i, channel_b_output_disable_i} = '0;
        {channel_d_output_disable_i, dual_pwm_mode_bit_i, pwm_b_i, pwm_d_i, timer_b_output_disable_i} = '0;
        {port2_direction_i, port8_direction_i, irq_enable_i, timer_mode_field_i, chip_select_mode_field_i} = '0;
        {timer_j0_pin_route_i, channel_b_route_field_i, channel_b_io_control_i, channel_d_io_control_i} = '0;
        timer_j0_output_disable_i = 1'b1;
        // Port 5 is not part of this block, so its input-only pin never sees a direction
        {port2_data_i, port8_data_i, port2_pullup_i, port8_pullup_i} = $random(seed);
        {serial_cs_i, serial_clk_i, serial_data_i, timer_j0_out_i, channel_b_wave_i, channel_d_wave_i} = 6'($random(seed));
        {timer_b_wave_i, port8_high_drive_i} = 10'($random(seed));
    endtask
    task automatic wr(logic [9:0] a, logic [7:0] v);
        reg_addr_i = a;
        reg_wdata_i = v;
        reg_wr_i = 1'b1;
        tick(1);
        reg_wr_i = 1'b0;
        reg_addr_i = PPFS_THRESH_ADDR;
        tick(2);
    endtask
    task automatic tally_and_finish();
        $display("Comparisons %0d, mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    function automatic logic [7:0] sel(int id);
        case (id)
            0: return reg_rdata_o;
            1: return port2_pin_o;
            2: return port2_pin_oe_o;
            3: return port8_pin_o;
            4: return port8_pin_oe_o;
            5: return port2_pullup_o;
            6: return port8_pullup_o;
            7: return port8_high_drive_o;
            8: return {4'h0, port9_threshold_o, port8_threshold_o};
            9: return irq_in_o;
            default: return {serial_cs_in_o, serial_clk_in_o, serial_data_in_o, channel_b_capture_o,
                             channel_d_capture_o, twowire_scl_in_o, twowire_sda_in_o, 1'b0};
        endcase
    endfunction
    // Monitor: every note queued by the driver is compared at the next edge
    always @(posedge clock_i) begin
        while (notes.size() > 0) begin
            n = notes.pop_front();
            compares++;
            if ((sel(n.id) & n.mask) !== n.val) begin
                err_count++;
                $display("MISMATCH output %0d expected %h seen %h", n.id, n.val, sel(n.id) & n.mask);
            end
        end
    end
    // Watchdog: the sequence needs well under a thousand cycles
    initial begin
        #(20000 * 5);
        err_count++;
        tally_and_finish();
    end
    //------------------------------------------------------------------
    // Main sequence
    //------------------------------------------------------------------
    initial begin
        {clock_i, reset_n_i, err_count, compares, seed, ext_en, ext_val, reg_wdata_i} = {2'b00, 64'd0, 32'd48, 40'd0};
        reg_addr_i = PPFS_THRESH_ADDR;
        idle();
        tick(2);
        reset_n_i = 1'b1;
        tick(2);
        chk(0, 8'hFF, PPFS_THRESH_RESET);
        chk(10, 8'h06, 8'h06);
        for (int c = 0; c < 4; c++) begin
            d = (c == 3) ? 8'hFF : {4'($random(seed)), 2'((c + 1) % 3), 2'(c)};
            wr(PPFS_THRESH_ADDR, d);
            chk(0, 8'hFF, {4'h0, d[3:0]});
            chk(8, 8'hFF, {4'h0, d[3:2], d[1:0]});
        end
        wr(10'h1F6, 8'h00);
        reg_addr_i = 10'h1F6;
        tick(2);
        chk(0, 8'hFF, 8'h00);
        chk(8, 8'hFF, 8'h0F);
        // Timer B modes override any direction
        for (int m = 1; m < 4; m++) begin
            idle();
            port2_direction_i = 8'($random(seed));
            timer_mode_field_i = 4'(m * 5);
            tick(6);
            chk(2, 8'h03, 8'h03);
            chk(1, 8'h03, {6'h00, timer_b_wave_i[0], timer_b_wave_i[1]});
        end
        timer_b_output_disable_i = 2'h3;
        tick(6);
        chk(1, 8'h03, port2_data_i & 8'h03);
        // Pull-up and drive strength follow the pin's role
        idle();
        {port2_direction_i, port8_direction_i} = 16'hFFFF;
        tick(6);
        chk(5, 8'hFF, 8'h00);
        chk(7, 8'hFF, port8_high_drive_i);
        chk(3, 8'hFF, port8_data_i);
        {port2_direction_i, port8_direction_i, irq_enable_i, ext_en, ext_val} = {16'h0000, 8'($random(seed)), 16'hFFFF, 16'($random(seed))};
        tick(6);
        chk(6, 8'hFF, port8_pullup_i);
        chk(7, 8'hFF, 8'h00);
        chk(9, 8'hFF, irq_enable_i & {ext_val[7:4], ext_val[9:8], ext_val[3:2]});
        {port2_direction_i, port8_direction_i} = 16'hFFFF;
        tick(6);
        chk(9, 8'hFF, 8'h00);
        // Chip-select pin: output, open-drain output, input
        idle();
        chip_select_mode_field_i = 2'h2;
        tick(6);
        chk(3, 8'h01, {7'h00, serial_cs_i});
        chip_select_open_drain_i = 1'b1;
        for (int v = 0; v < 2; v++) begin
            serial_cs_i = v[0];
            tick(6);
            chk(4, 8'h01, {7'h00, ~serial_cs_i});
        end
        chip_select_mode_field_i = 2'h1;
        tick(6);
        chk(4, 8'h01, 8'h00);
        chk(10, 8'h80, {ext_val[8], 7'h00});
        // Open-drain serial clock taken as input, its direction bit kept clear
        idle();
        {serial_clock_select_i, serial_open_drain_i} = 2'b11;
        tick(6);
        chk(10, 8'h40, {1'b0, ext_val[10], 6'h00});
        // Serial data on the shared pin, then open-drain, then bidirectional
        {serial_clock_select_i, serial_open_drain_i, serial_data_out_en_i} = 3'b001;
        tick(6);
        chk(3, 8'h08, {4'h0, serial_data_i, 3'h0});
        {serial_open_drain_i, serial_data_i} = 2'b11;
        tick(6);
        chk(4, 8'h08, 8'h00);
        bidirectional_mode_i = 1'b1;
        tick(6);
        chk(3, 8'h02, 8'h02);
        chk(4, 8'h02, 8'h02);
        // Two-wire bus pins
        idle();
        {serial_twowire_switch_i, twowire_interface_enable_i} = 2'b11;
        tick(6);
        chk(10, 8'h06, {5'h00, ext_val[10], ext_val[11], 1'b0});
        {twowire_scl_low_i, twowire_sda_low_i} = 2'b11;
        tick(6);
        chk(4, 8'h0C, 8'h0C);
        // Timer RC channel routing, PWM, compare and capture
        idle();
        channel_b_route_field_i = PPFS_CB_P84;
        tick(6);
        chk(3, 8'h10, {3'h0, channel_b_wave_i, 4'h0});
        {channel_b_route_field_i, dual_pwm_mode_bit_i, pwm_b_i} = {PPFS_CB_P86, 2'b11};
        tick(6);
        chk(4, 8'h50, 8'h40);
        chk(3, 8'h40, {1'b0, channel_b_wave_i, 6'h00});
        {pwm_b_i, channel_b_io_control_i} = {1'b0, 3'(1 + {$random(seed)} % 3)};
        tick(6);
        chk(4, 8'h40, 8'h40);
        channel_b_io_control_i = 3'h4;
        tick(6);
        chk(4, 8'h40, 8'h00);
        chk(10, 8'h10, {3'h0, ext_val[14], 4'h0});
        {channel_b_route_field_i, channel_b_io_control_i} = {PPFS_CB_NONE, 3'h0};
        tick(6);
        chk(4, 8'h50, 8'h00);
        {channel_b_route_field_i, channel_d_route_bit_i, pwm_d_i} = {PPFS_CB_P84, 2'b11};
        tick(6);
        chk(3, 8'h10, {3'h0, channel_d_wave_i, 4'h0});
        tick(2);
        tally_and_finish();
    end
endmodule
`default_nettype wire
